// >>> rtl/status_event_pkg.sv
// Constants and types for the status and event reporting bank
package status_event_pkg;

    localparam int DATA_W = 8;

    // Event status bits
    localparam int EV_PON = 7;
    localparam int EV_CMD = 5;
    localparam int EV_EXE = 4;
    localparam int EV_QRY = 2;
    localparam int EV_OPC = 0;
    localparam logic [7:0] EV_USED = 8'hb5;
    localparam logic [7:0] EV_RESET = 8'h80;

    // Status byte bits
    localparam int SB_RQS = 6;
    localparam int SB_ESB = 5;
    localparam int SB_MAV = 4;
    localparam int SB_TRIP = 1;
    localparam logic [7:0] MASK_RESET = 8'h00;

    // Execution error codes
    localparam logic [7:0] EXE_NONE = 8'h00;
    localparam logic [7:0] EXE_RANGE = 8'h65;
    localparam logic [7:0] EXE_MODE = 8'h66;
    localparam logic [7:0] EXE_FUNC = 8'h67;

    // Query error codes
    localparam logic [7:0] QRY_NONE = 8'h00;
    localparam logic [7:0] QRY_INTERRUPTED = 8'h01;
    localparam logic [7:0] QRY_DEADLOCK = 8'h02;
    localparam logic [7:0] QRY_UNTERMINATED = 8'h03;

    // Execution error causes
    typedef enum logic [1:0] {
        EXE_CAUSE_RANGE = 2'b01,
        EXE_CAUSE_MODE = 2'b10,
        EXE_CAUSE_FUNC = 2'b11
    } exe_cause_t;

    // Query selects, one-cycle strobe
    typedef enum logic [3:0] {
        Q_NONE = 4'h0,
        Q_EVENT = 4'h1,
        Q_EVENT_MASK = 4'h2,
        Q_EXE_CODE = 4'h3,
        Q_QRY_CODE = 4'h4,
        Q_STATUS = 4'h5,
        Q_SRQ_MASK = 4'h6,
        Q_PP_MASK = 4'h7,
        Q_IST = 4'h8,
        Q_TRIP = 4'h9,
        Q_TRIP_MASK = 4'ha
    } query_t;

    // Write selects, one-cycle strobe
    typedef enum logic [2:0] {
        W_NONE = 3'h0,
        W_EVENT_MASK = 3'h1,
        W_SRQ_MASK = 3'h2,
        W_PP_MASK = 3'h3,
        W_TRIP_MASK = 3'h4
    } write_t;

endpackage

// >>> rtl/status_event_reporting.sv
// Status and event reporting register bank
`timescale 1ns/100ps
module status_event_reporting
    import status_event_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic init_done,
    input wire logic syntax_error,
    input wire logic exe_error,
    input wire exe_cause_t exe_cause,
    input wire logic opc_cmd,
    input wire logic clear_status,
    input wire logic [2:0] write_sel,
    input wire logic [7:0] write_data,
    input wire logic [3:0] query_sel,
    input wire logic serial_poll,
    input wire logic response_ready,
    input wire logic terminator_sent,
    input wire logic talk_addressed,
    input wire logic formatter_idle,
    input wire logic queue_empty,
    input wire logic queue_full,
    input wire logic terminator_parsed,
    input wire logic extra_end,
    input wire logic [7:0] trip_condition,
    output logic [7:0] read_data,
    output logic read_valid,
    output logic poll_data_valid,
    output logic service_request,
    output logic ist,
    output logic parser_reset,
    output logic response_discard
);

    logic [7:0] event_status;
    logic [7:0] event_status_mask;
    logic [7:0] execution_error_code;
    logic [7:0] query_error_code;
    logic [7:0] service_request_mask;
    logic [7:0] parallel_poll_mask;
    logic [7:0] input_trip_flags;
    logic [7:0] input_trip_mask;
    logic mav;
    logic rqs;
    logic esb;
    logic input_trip_summary;
    logic mss;
    logic [7:0] status_summary_byte;
    logic q_unterm;
    logic q_dead;
    logic q_input_trip_summary;
    logic query_error;
    logic trip_pending;
    logic next_ist;
    logic [7:0] event_sets;
    logic srq_spent;
    query_t q;
    write_t w;

    assign q = query_t'(query_sel);
    assign w = write_t'(write_sel);

    // ------------------------------------------------------------
    // Summary logic
    // ------------------------------------------------------------
    assign esb = |(event_status & event_status_mask);
    assign input_trip_summary = |(input_trip_flags & input_trip_mask);
    assign mss = |({1'b0, 1'b0, esb, mav, 2'b00, input_trip_summary, 1'b0}
        & service_request_mask);
    // Unused bits held at zero
    assign status_summary_byte = {1'b0, mss, esb, mav, 2'b00,
        input_trip_summary, 1'b0};
    assign next_ist = |(status_summary_byte & parallel_poll_mask);

    // ------------------------------------------------------------
    // Query error detection
    // ------------------------------------------------------------
    assign q_unterm = talk_addressed && formatter_idle && queue_empty;
    assign q_dead = mav && queue_full;
    assign q_input_trip_summary = mav && (terminator_parsed || extra_end);
    assign query_error = q_unterm || q_dead || q_input_trip_summary;

    // ------------------------------------------------------------
    // Event status register
    // ------------------------------------------------------------
    always_comb begin
        event_sets = 8'h00;
        event_sets[EV_PON] = init_done;
        event_sets[EV_CMD] = syntax_error;
        event_sets[EV_EXE] = exe_error;
        event_sets[EV_QRY] = query_error;
        event_sets[EV_OPC] = opc_cmd;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            event_status <= EV_RESET;
        end else if (q == Q_EVENT || clear_status) begin
            // Set wins over clear
            event_status <= event_sets & EV_USED;
        end else begin
            event_status <= (event_status | event_sets) & EV_USED;
        end
    end

    // ------------------------------------------------------------
    // Execution error code
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            execution_error_code <= EXE_NONE;
        end else if (exe_error) begin
            unique case (exe_cause)
                EXE_CAUSE_RANGE: execution_error_code <= EXE_RANGE;
                EXE_CAUSE_MODE: execution_error_code <= EXE_MODE;
                EXE_CAUSE_FUNC: execution_error_code <= EXE_FUNC;
                default: execution_error_code <= EXE_RANGE;
            endcase
        end else if (q == Q_EXE_CODE || clear_status) begin
            execution_error_code <= EXE_NONE;
        end
    end

    // ------------------------------------------------------------
    // Query error code
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            query_error_code <= QRY_NONE;
        end else if (q_unterm) begin
            query_error_code <= QRY_UNTERMINATED;
        end else if (q_dead) begin
            query_error_code <= QRY_DEADLOCK;
        end else if (q_input_trip_summary) begin
            query_error_code <= QRY_INTERRUPTED;
        end else if (q == Q_QRY_CODE || clear_status) begin
            query_error_code <= QRY_NONE;
        end
    end

    // ------------------------------------------------------------
    // Mask registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            event_status_mask <= MASK_RESET;
            service_request_mask <= MASK_RESET;
            parallel_poll_mask <= MASK_RESET;
            input_trip_mask <= MASK_RESET;
        end else begin
            unique case (w)
                W_EVENT_MASK: event_status_mask <= write_data;
                W_SRQ_MASK: service_request_mask <= write_data;
                W_PP_MASK: parallel_poll_mask <= write_data;
                W_TRIP_MASK: input_trip_mask <= write_data;
                W_NONE: ;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Input trip flags
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            input_trip_flags <= 8'h00;
            trip_pending <= 1'b0;
        end else begin
            trip_pending <= (q == Q_TRIP);
            if (trip_pending || clear_status) begin
                // After response only live conditions remain
                input_trip_flags <= trip_condition;
            end else begin
                input_trip_flags <= input_trip_flags | trip_condition;
            end
        end
    end

    // ------------------------------------------------------------
    // Message available and parser control
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mav <= 1'b0;
            parser_reset <= 1'b0;
            response_discard <= 1'b0;
        end else begin
            if (q_dead || q_input_trip_summary) begin
                mav <= 1'b0;
            end else if (response_ready) begin
                mav <= 1'b1;
            end else if (terminator_sent) begin
                mav <= 1'b0;
            end
            parser_reset <= syntax_error || q_unterm;
            response_discard <= q_dead || q_input_trip_summary;
        end
    end

    // ------------------------------------------------------------
    // Service request and parallel poll
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rqs <= 1'b0;
            service_request <= 1'b0;
            srq_spent <= 1'b0;
            ist <= 1'b0;
        end else begin
            if (!mss) begin
                rqs <= 1'b0;
                service_request <= 1'b0;
                srq_spent <= 1'b0;
            end else if (!srq_spent) begin
                // One request per rise of the summary
                rqs <= 1'b1;
                service_request <= 1'b1;
                srq_spent <= 1'b1;
            end else if (serial_poll) begin
                rqs <= 1'b0;
                service_request <= 1'b0;
            end
            ist <= next_ist;
        end
    end

    // ------------------------------------------------------------
    // Read answers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            read_data <= 8'h00;
            read_valid <= 1'b0;
            poll_data_valid <= 1'b0;
        end else begin
            read_valid <= (q != Q_NONE) || serial_poll;
            poll_data_valid <= serial_poll;
            if (serial_poll) begin
                read_data <= {1'b0, rqs, status_summary_byte[5:0]};
            end else begin
                unique case (q)
                    Q_EVENT: read_data <= event_status;
                    Q_EVENT_MASK: read_data <= event_status_mask;
                    Q_EXE_CODE: read_data <= execution_error_code;
                    Q_QRY_CODE: read_data <= query_error_code;
                    Q_STATUS: read_data <= status_summary_byte;
                    Q_SRQ_MASK: read_data <= service_request_mask;
                    Q_PP_MASK: read_data <= parallel_poll_mask;
                    Q_IST: read_data <= {7'h00, next_ist};
                    Q_TRIP: read_data <= input_trip_flags;
                    Q_TRIP_MASK: read_data <= input_trip_mask;
                    default: read_data <= 8'h00;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_unused_event_bits;
        @(posedge clk) disable iff (!nrst)
        (event_status & ~EV_USED) == 8'h00;
    endproperty
    a_unused_event_bits: assert property (p_unused_event_bits)
        else $error("unused event bit set");

    property p_opc_sets;
        @(posedge clk) disable iff (!nrst)
        opc_cmd |=> event_status[EV_OPC];
    endproperty
    a_opc_sets: assert property (p_opc_sets)
        else $error("opc bit not set");

    property p_opc_only;
        @(posedge clk) disable iff (!nrst)
        !opc_cmd && !event_status[EV_OPC] |=> !event_status[EV_OPC];
    endproperty
    a_opc_only: assert property (p_opc_only)
        else $error("opc bit set without command");

    property p_event_read_clears;
        @(posedge clk) disable iff (!nrst)
        q == Q_EVENT && !init_done && !syntax_error && !exe_error &&
            !query_error && !opc_cmd |=> event_status == 8'h00;
    endproperty
    a_event_read_clears: assert property (p_event_read_clears)
        else $error("event status not cleared by read");

    property p_exe_sets_bit4;
        @(posedge clk) disable iff (!nrst)
        exe_error |=> event_status[EV_EXE] && execution_error_code != 8'h00;
    endproperty
    a_exe_sets_bit4: assert property (p_exe_sets_bit4)
        else $error("execution error not reported");

    property p_unterm;
        @(posedge clk) disable iff (!nrst)
        q_unterm |=> query_error_code == QRY_UNTERMINATED &&
            event_status[EV_QRY] && parser_reset;
    endproperty
    a_unterm: assert property (p_unterm)
        else $error("unterminated error not reported");

    property p_deadlock;
        @(posedge clk) disable iff (!nrst)
        q_dead && !q_unterm |=> query_error_code == QRY_DEADLOCK && !mav;
    endproperty
    a_deadlock: assert property (p_deadlock)
        else $error("deadlock error not reported");

    property p_ist;
        @(posedge clk) disable iff (!nrst)
        ##1 ist == $past(|(status_summary_byte & parallel_poll_mask));
    endproperty
    a_ist: assert property (p_ist)
        else $error("ist mismatch");

    property p_status_zero_bits;
        @(posedge clk) disable iff (!nrst)
        (status_summary_byte & 8'h8d) == 8'h00;
    endproperty
    a_status_zero_bits: assert property (p_status_zero_bits)
        else $error("unused status bit set");

    property p_poll_clears_rqs;
        @(posedge clk) disable iff (!nrst)
        serial_poll && rqs |=> !rqs && !service_request;
    endproperty
    a_poll_clears_rqs: assert property (p_poll_clears_rqs)
        else $error("poll did not clear request");

    property p_rose_mss;
        @(posedge clk) disable iff (!nrst)
        $rose(mss) |=> rqs && service_request;
    endproperty
    a_rose_mss: assert property (p_rose_mss)
        else $error("summary rise raised no request");

    property p_not_rearmed;
        @(posedge clk) disable iff (!nrst)
        $fell(rqs) && $past(mss) && mss |=> !rqs;
    endproperty
    a_not_rearmed: assert property (p_not_rearmed)
        else $error("request raised again while summary held");

    property p_mav_sets;
        @(posedge clk) disable iff (!nrst)
        response_ready && !q_dead && !q_input_trip_summary |=> mav;
    endproperty
    a_mav_sets: assert property (p_mav_sets)
        else $error("message available not set");

    property p_mav_clears;
        @(posedge clk) disable iff (!nrst)
        terminator_sent && !response_ready |=> !mav;
    endproperty
    a_mav_clears: assert property (p_mav_clears)
        else $error("message available not cleared");

    property p_interrupted;
        @(posedge clk) disable iff (!nrst)
        q_input_trip_summary && !q_unterm && !q_dead |=> query_error_code ==
            QRY_INTERRUPTED && !mav && response_discard && event_status[EV_QRY];
    endproperty
    a_interrupted: assert property (p_interrupted)
        else $error("interrupted error not reported");

    property p_trip_hold;
        @(posedge clk) disable iff (!nrst)
        !trip_pending && !clear_status |=>
            ($past(input_trip_flags) & ~input_trip_flags) == 8'h00;
    endproperty
    a_trip_hold: assert property (p_trip_hold)
        else $error("trip flag cleared before query");

endmodule

// >>> tb/remote_controller.sv
// Remote controller model issuing queries, writes and serial polls
`timescale 1ns/100ps
module remote_controller
    import status_event_pkg::*;
(
    input wire logic clk,
    input wire logic read_valid,
    output logic [3:0] query_sel,
    output logic [2:0] write_sel,
    output logic [7:0] write_data,
    output logic serial_poll
);
    initial begin
        query_sel = Q_NONE;
        write_sel = W_NONE;
        write_data = 8'h00;
        serial_poll = 1'b0;
    end

    // One-cycle query or poll, answer flag taken at the next falling edge
    task automatic ask(input query_t q, input logic poll, output logic ok);
        @(negedge clk);
        query_sel = q;
        serial_poll = poll;
        @(negedge clk);
        ok = read_valid;
        query_sel = Q_NONE;
        serial_poll = 1'b0;
    endtask

    // One-cycle mask write, data scrambled once released
    task automatic put(input write_t w, input logic [7:0] d);
        @(negedge clk);
        write_sel = w;
        write_data = d;
        @(negedge clk);
        write_sel = W_NONE;
        write_data = ~d;
    endtask
endmodule

// >>> tb/status_event_reporting_tb.sv
// Self-checking testbench for the status and event reporting bank
`timescale 1ns/100ps
module status_event_reporting_tb;
    import status_event_pkg::*;
    logic clk, nrst, init_done, syntax_error, exe_error, opc_cmd;
    logic clear_status, serial_poll, response_ready, terminator_sent;
    logic talk_addressed, formatter_idle, queue_empty, queue_full;
    logic terminator_parsed, extra_end, read_valid, poll_data_valid;
    logic service_request, ist, parser_reset, response_discard, ok;
    logic [1:0] pr;
    logic [2:0] write_sel;
    logic [3:0] query_sel;
    logic [7:0] write_data, trip_condition, read_data;
    exe_cause_t exe_cause;
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;

    status_event_reporting i_dut (.clk(clk), .nrst(nrst),
        .init_done(init_done), .syntax_error(syntax_error),
        .exe_error(exe_error), .exe_cause(exe_cause), .opc_cmd(opc_cmd),
        .clear_status(clear_status), .write_sel(write_sel),
        .write_data(write_data), .query_sel(query_sel),
        .serial_poll(serial_poll), .response_ready(response_ready),
        .terminator_sent(terminator_sent), .talk_addressed(talk_addressed),
        .formatter_idle(formatter_idle), .queue_empty(queue_empty),
        .queue_full(queue_full), .terminator_parsed(terminator_parsed),
        .extra_end(extra_end), .trip_condition(trip_condition),
        .read_data(read_data), .read_valid(read_valid),
        .poll_data_valid(poll_data_valid),
        .service_request(service_request), .ist(ist),
        .parser_reset(parser_reset), .response_discard(response_discard));

    remote_controller i_ctrl (.clk(clk), .read_valid(read_valid),
        .query_sel(query_sel), .write_sel(write_sel),
        .write_data(write_data), .serial_poll(serial_poll));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic end_of_test;
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input query_t q, input logic [7:0] exp);
        i_ctrl.ask(q, 1'b0, ok);
        check({7'h00, ok}, 8'h01);
        check(read_data, exp);
    endtask

    task automatic wr(input write_t w, input logic [7:0] d);
        i_ctrl.put(w, d);
    endtask

    // One-cycle event strobe; returns parser reset and discard pulses
    task automatic strobe(input int k);
        @(negedge clk);
        case (k)
            0: init_done = 1'b1;
            1: syntax_error = 1'b1;
            2: exe_error = 1'b1;
            3: opc_cmd = 1'b1;
            4: clear_status = 1'b1;
            5: response_ready = 1'b1;
            default: terminator_sent = 1'b1;
        endcase
        @(negedge clk);
        pr = {parser_reset, response_discard};
        {init_done, syntax_error, exe_error, opc_cmd} = 4'h0;
        {clear_status, response_ready, terminator_sent} = 3'h0;
    endtask

    // One-cycle bus condition levels
    task automatic cond(input logic [5:0] v);
        @(negedge clk);
        {talk_addressed, formatter_idle, queue_empty} = v[5:3];
        {queue_full, terminator_parsed, extra_end} = v[2:0];
        @(negedge clk);
        pr = {parser_reset, response_discard};
        {talk_addressed, formatter_idle, queue_empty} = 3'h0;
        {queue_full, terminator_parsed, extra_end} = 3'h0;
    endtask

    // ----------------------------------------
    // Clock, timeout and tests
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            end_of_test();
        end
    end

    initial begin
        {init_done, syntax_error, exe_error, opc_cmd} = 4'h0;
        {clear_status, response_ready, terminator_sent} = 3'h0;
        {talk_addressed, formatter_idle, queue_empty} = 3'h0;
        {queue_full, terminator_parsed, extra_end} = 3'h0;
        exe_cause = EXE_CAUSE_RANGE;
        trip_condition = 8'h00;
        pr = 2'b00;
        nrst = 1'b0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        rd(Q_EVENT, 8'h80);
        rd(Q_EVENT, 8'h00);
        for (int q = 2; q <= 10; q++) begin
            rd(query_t'(q), 8'h00);
        end
        strobe(0);
        rd(Q_EVENT, 8'h80);
        wr(W_EVENT_MASK, 8'hff);
        rd(Q_EVENT_MASK, 8'hff);
        strobe(1);
        check({7'h00, pr[1]}, 8'h01);
        for (int c = 1; c <= 3; c++) begin
            exe_cause = exe_cause_t'(c);
            strobe(2);
            rd(Q_EXE_CODE, 8'h64 + 8'(c));
        end
        rd(Q_EXE_CODE, 8'h00);
        strobe(3);
        rd(Q_STATUS, 8'h20);
        rd(Q_EVENT, 8'h31);
        rd(Q_STATUS, 8'h00);
        wr(W_EVENT_MASK, 8'hef);
        strobe(2);
        rd(Q_STATUS, 8'h00);
        rd(Q_EVENT, 8'h10);
        wr(W_EVENT_MASK, 8'h01);
        wr(W_SRQ_MASK, 8'h20);
        strobe(3);
        @(negedge clk);
        check({7'h00, service_request}, 8'h01);
        rd(Q_STATUS, 8'h60);
        i_ctrl.ask(Q_NONE, 1'b1, ok);
        check({ok, poll_data_valid, read_data[6]}, 8'h07);
        check({7'h00, service_request}, 8'h00);
        rd(Q_STATUS, 8'h60);
        check({7'h00, service_request}, 8'h00);
        wr(W_PP_MASK, 8'h20);
        rd(Q_IST, 8'h01);
        strobe(4);
        rd(Q_STATUS, 8'h00);
        check({7'h00, ist}, 8'h00);
        strobe(5);
        rd(Q_STATUS, 8'h10);
        strobe(6);
        rd(Q_STATUS, 8'h00);
        for (int i = 0; i < 4; i++) begin
            if (i > 0) strobe(5);
            cond(i == 0 ? 6'h38 : 6'h08 >> i);
            check({6'h00, pr}, i == 0 ? 8'h02 : 8'h01);
            rd(Q_QRY_CODE, i == 0 ? 8'h03 : (i == 1 ? 8'h02 : 8'h01));
            rd(Q_QRY_CODE, 8'h00);
        end
        rd(Q_EVENT, 8'h04);
        strobe(6);
        wr(W_TRIP_MASK, 8'h01);
        @(negedge clk);
        trip_condition = 8'h01;
        repeat (2) @(negedge clk);
        rd(Q_STATUS, 8'h02);
        trip_condition = 8'h00;
        rd(Q_TRIP, 8'h01);
        repeat (2) @(negedge clk);
        rd(Q_TRIP, 8'h00);
        rd(Q_TRIP_MASK, 8'h01);
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        rd(Q_EVENT, 8'h80);
        rd(Q_SRQ_MASK, 8'h00);
        rd(Q_PP_MASK, 8'h00);
        rd(Q_TRIP_MASK, 8'h00);
        end_of_test();
    end
endmodule
